// >>> hw/argl_pkg.sv
// Purpose: Shared constants for the result gain and limit check
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   Upper bits of every 16-bit register read as zero
package argl_pkg;
   // Bus and field widths
   localparam int          ADDR_W        = 16;
   localparam int          DATA_W        = 32;
   localparam int          RES_W         = 16;
   localparam int          GAIN_W        = 15;
   localparam int          NFLAG         = 3;

   // Register byte offsets
   localparam logic [15:0] OFS_LOW_THR   = 16'h20a8;
   localparam logic [15:0] OFS_LOW_REL   = 16'h20ac;
   localparam logic [15:0] OFS_HIGH_THR  = 16'h20b0;
   localparam logic [15:0] OFS_HIGH_REL  = 16'h20b4;
   localparam logic [15:0] OFS_STEP_LIM  = 16'h20b8;
   localparam logic [15:0] OFS_BANK_A    = 16'h20c0;
   localparam logic [15:0] OFS_BANK_B    = 16'h20c4;
   localparam logic [15:0] OFS_IRQ_MASK  = 16'h20c8;
   localparam logic [15:0] OFS_CHECK_CTL = 16'h20cc;
   localparam logic [15:0] OFS_LIVE      = 16'h20d0;
   localparam logic [15:0] OFS_TEMP_GAIN = 16'h2238;

   // Reset values and the illegal zero gain code
   localparam logic [15:0] RST_LIMIT     = 16'h0000;
   localparam logic [14:0] RST_GAIN      = 15'h4000;
   localparam logic [14:0] GAIN_ZERO     = 15'h0000;
   localparam logic [2:0]  RST_FLAGS     = 3'h0;
   localparam logic [5:0]  RST_MASK      = 6'h00;

   // Gain format: unsigned, bit 14 integer, bits 13:0 fraction
   localparam int          GAIN_FRAC     = 14;
   localparam int          GAIN_SIGN     = 14;

   // Flag positions inside each bank
   localparam int          FLG_LOW       = 0;
   localparam int          FLG_HIGH      = 1;
   localparam int          FLG_STEP      = 2;

   // Check control fields: enables then bank routing
   localparam int          CTL_EN_LSB    = 0;
   localparam int          CTL_ROUTE_LSB = 4;
   // Mask fields: bank a low, bank b high
   localparam int          MASK_B_LSB    = 3;

   localparam logic [15:0] RES_MAX       = 16'hffff;
   localparam logic [15:0] RES_MIN       = 16'h0000;

   // Bus slave states
   typedef enum logic [0:0] {
      ARGL_IDLE = 1'b0,
      ARGL_ACK  = 1'b1
   } argl_bus_st_t;
endpackage : argl_pkg

// >>> hw/argl_gain.sv
// Purpose: Unsigned fixed-point gain on temperature channel results
// Assumes: Raw result is unsigned, gain code bit 14 marks unity
// Notes:   One cycle of latency, output registered
`timescale 1ns/1ns
module argl_gain (
   input  wire logic        core_clk,  // System clock
   input  wire logic        reset_n,   // Sync reset, active low
   input  wire logic        in_valid,  // Raw result strobe
   input  wire logic [15:0] in_data,   // Raw result
   input  wire logic        in_temp,   // Result from temp sensor
   input  wire logic [14:0] gain,      // Gain code
   output logic             out_valid, // Corrected strobe
   output logic [15:0]      out_data   // Corrected result
);
   logic        [31:0] prod;
   logic        [31:0] scaled;
   logic        [15:0] sat;
   logic        [15:0] next_data;

   // Bit 14 set means gain at or above unity, so the code scales
   // as an unsigned 1.14 value: raw times code over 16384
   assign prod   = {16'h0000, in_data} * {17'h0, gain};
   assign scaled = prod >> argl_pkg::GAIN_FRAC;
   // Product never goes negative; overflow clamps to full scale
   assign sat = (|scaled[31:16]) ? argl_pkg::RES_MAX :
                scaled[15:0];
   // Zero code is illegal and forces zero; other channels bypass
   assign next_data = !in_temp ? in_data :
                      (gain == argl_pkg::GAIN_ZERO) ?
                      argl_pkg::RES_MIN : sat;

   // Output register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_data  <= argl_pkg::RES_MIN;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_data <= next_data;
         end
      end
   end
endmodule : argl_gain

// >>> hw/argl_step.sv
// Purpose: Difference check between consecutive results
// Assumes: Results arrive as single-cycle strobes
// Notes:   First result after reset only primes the history
`timescale 1ns/1ns
module argl_step (
   input  wire logic        core_clk, // System clock
   input  wire logic        reset_n,  // Sync reset, active low
   input  wire logic        valid,    // Result strobe
   input  wire logic [15:0] data,     // Corrected result
   input  wire logic [15:0] limit,    // Allowed difference
   output logic             trip      // Difference too large
);
   logic        [15:0] prev;
   logic               have_prev;
   logic        [15:0] diff;

   // Magnitude of the change, no wrap since operands unsigned
   assign diff = (data >= prev) ? (data - prev) : (prev - data);
   assign trip = valid & have_prev & (diff > limit);

   // History of the previous result
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         prev      <= argl_pkg::RES_MIN;
         have_prev <= 1'b0;
      end else if (valid) begin
         prev      <= data;
         have_prev <= 1'b1;
      end
   end
endmodule : argl_step

// >>> hw/argl_top.sv
// Purpose: Gain correction and limit checks on the result stream
// Assumes: Result strobes come from logic on core_clk
// Notes:   APB slave with one wait state, sticky flag banks
// Functional notes
// - The gain code is 15-bit unsigned, bit 14 integer, 14 fraction bits.
// - A gain code of zero is illegal and yields a result of zero.
// - Code 0x4000 is unity and reset, 0x2000 halves, 0x7fff near doubles.
// - Gain correction applies only to temperature sensor results.
// - A result below the low threshold sets the low-limit flag.
// - The low-limit flag holds until a result exceeds threshold plus margin.
// - Each result is compared to the high threshold, tripping its flag.
// - High trips above threshold, holds until below threshold minus margin.
// - Consecutive results differing by more than the step limit flag it.
// - Threshold, margin and step registers reset to zero, upper half reads 0.
`timescale 1ns/1ns
module argl_top (
   input  wire logic        core_clk,   // System clock, 100 MHz
   input  wire logic        reset_n,    // Sync reset, active low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB direction
   input  wire logic [15:0] paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic      [31:0] prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB error, unmapped
   input  wire logic        res_valid,  // Raw result strobe
   input  wire logic [15:0] conversion_result, // Raw result
   input  wire logic        res_is_temp, // Result from temp sensor
   output logic             corr_valid, // Corrected strobe
   output logic      [15:0] corr_data,  // Corrected result
   output logic             irq         // Level interrupt
);
   // Flags per bank: low, high, step
   localparam int NF = argl_pkg::NFLAG;

   // Software registers
   logic [15:0]             low_threshold;
   logic [15:0]             low_release_margin;
   logic [15:0]             high_threshold;
   logic [15:0]             high_release_margin;
   logic [15:0]             step_limit;
   logic [14:0]             temp_gain_factor;
   logic [NF-1:0]           check_en;
   logic [NF-1:0]           bank_route;
   logic [NF-1:0]           interrupt_flag_bank_a;
   logic [NF-1:0]           interrupt_flag_bank_b;
   logic [2*NF-1:0]         irq_mask;

   // Live hysteresis and step state
   logic                    low_active;
   logic                    high_active;
   logic                    step_seen;

   // Bus slave state
   argl_pkg::argl_bus_st_t  bus_st;
   argl_pkg::argl_bus_st_t  next_bus_st;

   // Stage outputs
   logic                    g_valid;
   logic [15:0]             g_data;
   logic                    step_trip;

   // Gain correction stage; adds one cycle to every result
   // Other channels pass through it unchanged, only delayed
   argl_gain u_gain (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (res_valid),
      .in_data   (conversion_result),
      .in_temp   (res_is_temp),
      .gain      (temp_gain_factor),
      .out_valid (g_valid),
      .out_data  (g_data)
   );

   // Step check on corrected results
   // First result after reset only primes the history
   argl_step u_step (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .valid    (g_valid),
      .data     (g_data),
      .limit    (step_limit),
      .trip     (step_trip)
   );

   // Bus decode
   // Taken only while idle, so an access phase held over the
   // answer cycle is never taken twice.
   // Registered answer keeps the read mux off the pready path.
   // Unmapped addresses get pslverr; their writes are dropped.
   logic        acc_req;
   logic        wr_en;
   logic        hit_low_thr;
   logic        hit_low_rel;
   logic        hit_high_thr;
   logic        hit_high_rel;
   logic        hit_step;
   logic        hit_bank_a;
   logic        hit_bank_b;
   logic        hit_mask;
   logic        hit_ctl;
   logic        hit_live;
   logic        hit_gain;
   logic        hit_any;
   logic [31:0] rd_mux;

   // Access phase seen, answered one cycle later
   assign acc_req = psel & penable & (bus_st == argl_pkg::ARGL_IDLE);
   // Writes land on the edge that samples pready high
   assign wr_en   = psel & penable & pwrite & pready & ~pslverr;

   // Address compare per register
   assign hit_low_thr  = (paddr == argl_pkg::OFS_LOW_THR);
   assign hit_low_rel  = (paddr == argl_pkg::OFS_LOW_REL);
   assign hit_high_thr = (paddr == argl_pkg::OFS_HIGH_THR);
   assign hit_high_rel = (paddr == argl_pkg::OFS_HIGH_REL);
   assign hit_step     = (paddr == argl_pkg::OFS_STEP_LIM);
   assign hit_bank_a   = (paddr == argl_pkg::OFS_BANK_A);
   assign hit_bank_b   = (paddr == argl_pkg::OFS_BANK_B);
   assign hit_mask     = (paddr == argl_pkg::OFS_IRQ_MASK);
   assign hit_ctl      = (paddr == argl_pkg::OFS_CHECK_CTL);
   assign hit_live     = (paddr == argl_pkg::OFS_LIVE);
   assign hit_gain     = (paddr == argl_pkg::OFS_TEMP_GAIN);
   assign hit_any = hit_low_thr | hit_low_rel | hit_high_thr |
                    hit_high_rel | hit_step | hit_bank_a |
                    hit_bank_b | hit_mask | hit_ctl | hit_live |
                    hit_gain;

   // Read data, reserved upper bits read as zero
   assign rd_mux =
      hit_low_thr  ? {16'h0000, low_threshold}       :
      hit_low_rel  ? {16'h0000, low_release_margin}  :
      hit_high_thr ? {16'h0000, high_threshold}      :
      hit_high_rel ? {16'h0000, high_release_margin} :
      hit_step     ? {16'h0000, step_limit}          :
      hit_gain     ? {17'h00000, temp_gain_factor}   :
      hit_bank_a   ? {29'h00000000, interrupt_flag_bank_a} :
      hit_bank_b   ? {29'h00000000, interrupt_flag_bank_b} :
      hit_mask     ? {26'h0000000, irq_mask}         :
      hit_ctl      ? {25'h0000000, bank_route, 1'b0, check_en} :
      hit_live     ? {29'h00000000, step_seen, high_active,
                      low_active}                    :
      32'h00000000;

   // Slave state: idle until an access, then one acknowledge cycle
   always_comb begin
      next_bus_st = bus_st;
      case (bus_st)
         argl_pkg::ARGL_IDLE: begin
            if (acc_req) begin
               next_bus_st = argl_pkg::ARGL_ACK;
            end
         end
         argl_pkg::ARGL_ACK: begin
            next_bus_st = argl_pkg::ARGL_IDLE;
         end
         default: begin
            next_bus_st = argl_pkg::ARGL_IDLE;
         end
      endcase
   end

   // Bus answer registers
   // prdata changes only on reads, so it holds between transfers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bus_st  <= argl_pkg::ARGL_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         bus_st  <= next_bus_st;
         pready  <= acc_req;
         pslverr <= acc_req & ~hit_any;
         if (acc_req && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // Configuration registers
   // Writes land on the edge that samples pready high, never in
   // the setup cycle, so a stalled master sees no early update.
   // Reserved upper bits cost no flops and read back as zero.
   // Gain resets to unity so temperature results pass unchanged.
   // Limits and margins; only the low half is stored
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         low_threshold       <= argl_pkg::RST_LIMIT;
         low_release_margin  <= argl_pkg::RST_LIMIT;
         high_threshold      <= argl_pkg::RST_LIMIT;
         high_release_margin <= argl_pkg::RST_LIMIT;
         step_limit          <= argl_pkg::RST_LIMIT;
      end else if (wr_en) begin
         if (hit_low_thr) begin
            low_threshold <= pwdata[15:0];
         end
         if (hit_low_rel) begin
            low_release_margin <= pwdata[15:0];
         end
         if (hit_high_thr) begin
            high_threshold <= pwdata[15:0];
         end
         if (hit_high_rel) begin
            high_release_margin <= pwdata[15:0];
         end
         if (hit_step) begin
            step_limit <= pwdata[15:0];
         end
      end
   end

   // Gain, check enables, routing and mask
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         temp_gain_factor <= argl_pkg::RST_GAIN;
         check_en         <= argl_pkg::RST_FLAGS;
         bank_route       <= argl_pkg::RST_FLAGS;
         irq_mask         <= argl_pkg::RST_MASK;
      end else if (wr_en) begin
         if (hit_gain) begin
            temp_gain_factor <= pwdata[14:0];
         end
         if (hit_ctl) begin
            check_en   <= pwdata[argl_pkg::CTL_EN_LSB +: NF];
            bank_route <= pwdata[argl_pkg::CTL_ROUTE_LSB +: NF];
         end
         if (hit_mask) begin
            irq_mask <= pwdata[2*NF-1:0];
         end
      end
   end

   // Limit checks on each corrected result
   // Checks judge the corrected value, so a temperature result
   // is compared after its gain. Live state moves on strobes only.
   // Wider release arithmetic stops a large margin from wrapping
   // past the end of the range and releasing early.
   logic [16:0]        low_release;
   logic signed [17:0] high_release;
   logic               below_low;
   logic               above_low_rel;
   logic               above_high;
   logic               below_high_rel;
   logic               next_low_active;
   logic               next_high_active;
   logic [NF-1:0]      event_hit;

   // Release points widened so they cannot wrap
   // A negative high release point clears only through disable
   assign low_release  = {1'b0, low_threshold} +
                         {1'b0, low_release_margin};
   assign high_release = $signed({2'b00, high_threshold}) -
                         $signed({2'b00, high_release_margin});

   assign below_low      = g_data < low_threshold;
   assign above_low_rel  = {1'b0, g_data} > low_release;
   assign above_high     = g_data > high_threshold;
   assign below_high_rel = $signed({2'b00, g_data}) <
                           high_release;

   // Hysteresis: trip sets, the release point or a disabled check clears
   assign next_low_active =
      !check_en[argl_pkg::FLG_LOW] ? 1'b0 :
      below_low     ? 1'b1 :
      above_low_rel ? 1'b0 :
      low_active;
   assign next_high_active =
      !check_en[argl_pkg::FLG_HIGH] ? 1'b0 :
      above_high     ? 1'b1 :
      below_high_rel ? 1'b0 :
      high_active;

   // A flag event repeats on every result while the state holds
   // Disabled checks force live state low and raise no events
   assign event_hit[argl_pkg::FLG_LOW]  = g_valid & next_low_active;
   assign event_hit[argl_pkg::FLG_HIGH] = g_valid & next_high_active;
   assign event_hit[argl_pkg::FLG_STEP] =
      step_trip & check_en[argl_pkg::FLG_STEP];

   // Live state and corrected output
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         low_active  <= 1'b0;
         high_active <= 1'b0;
         step_seen   <= 1'b0;
         corr_valid  <= 1'b0;
         corr_data   <= argl_pkg::RES_MIN;
      end else begin
         corr_valid <= g_valid;
         if (g_valid) begin
            low_active  <= next_low_active;
            high_active <= next_high_active;
            step_seen   <= event_hit[argl_pkg::FLG_STEP];
            corr_data   <= g_data;
         end
      end
   end

   // Flag banks, write one to clear; a new event beats the clear
   // A clear meeting a fresh event in one cycle keeps the flag,
   // so software never loses an event between read and clear.
   // Each flag picks its bank by its routing bit; the other bank
   // is left alone.
   logic [NF-1:0] set_a;
   logic [NF-1:0] set_b;
   logic [NF-1:0] clr_a;
   logic [NF-1:0] clr_b;

   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_flag
         // Routing bit picks which bank sees the event
         assign set_a[gi] = event_hit[gi] & ~bank_route[gi];
         assign set_b[gi] = event_hit[gi] &  bank_route[gi];
         assign clr_a[gi] = wr_en & hit_bank_a & pwdata[gi];
         assign clr_b[gi] = wr_en & hit_bank_b & pwdata[gi];

         always_ff @(posedge core_clk) begin
            if (!reset_n) begin
               interrupt_flag_bank_a[gi] <= 1'b0;
               interrupt_flag_bank_b[gi] <= 1'b0;
            end else begin
               interrupt_flag_bank_a[gi] <= set_a[gi] |
                  (interrupt_flag_bank_a[gi] & ~clr_a[gi]);
               interrupt_flag_bank_b[gi] <= set_b[gi] |
                  (interrupt_flag_bank_b[gi] & ~clr_b[gi]);
            end
         end
      end
   endgenerate

   // Interrupt from masked flags; one cycle behind the flag
   // Mask bits [2:0] gate bank a, bits [5:3] gate bank b
   logic irq_any;
   assign irq_any =
      |(interrupt_flag_bank_a & irq_mask[NF-1:0]) |
      |(interrupt_flag_bank_b & irq_mask[argl_pkg::MASK_B_LSB +: NF]);

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_any;
      end
   end
endmodule : argl_top

// >>> tb/argl_checker.sv
// Purpose: Port-level checks for the gain and limit stage
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto every argl_top instance
`timescale 1ns/1ns
module argl_checker (
   input wire logic        core_clk,          // System clock
   input wire logic        reset_n,           // Sync reset, active low
   input wire logic        psel,              // APB select
   input wire logic        penable,           // APB enable
   input wire logic        pwrite,            // APB direction
   input wire logic [31:0] prdata,            // APB read data
   input wire logic        pready,            // APB ready
   input wire logic        pslverr,           // APB error
   input wire logic        res_valid,         // Raw result strobe
   input wire logic [15:0] conversion_result, // Raw result
   input wire logic        res_is_temp,       // Temp sensor result
   input wire logic        corr_valid,        // Corrected strobe
   input wire logic [15:0] corr_data          // Corrected result
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // Access phase still waiting for its answer
   sequence s_access;
      psel && penable && !pready;
   endsequence
   // Result that must pass the gain stage unchanged
   sequence s_raw;
      res_valid && !res_is_temp;
   endsequence

   // Bus handshake: one wait state, single-cycle answer
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   access_answer_a: assert property (s_access |=> pready)
      else $error("access phase not answered next cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_read_zero_a: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h0)
      else $error("refused read returned nonzero data");
   upper_zero_a: assert property (pready && !pwrite
      |-> prdata[31:16] == 16'h0)
      else $error("upper half of read data not zero");
   // Result stream: fixed two-cycle latency, data held between strobes
   result_latency_a: assert property (res_valid |-> ##2 corr_valid)
      else $error("corrected strobe missing two cycles after input");
   valid_cause_a: assert property (corr_valid |-> $past(res_valid, 2))
      else $error("corrected strobe without an input");
   bypass_data_a: assert property (s_raw |-> ##2
      corr_data == $past(conversion_result, 2))
      else $error("non-temperature result altered");
   data_held_a: assert property (!corr_valid |-> $stable(corr_data))
      else $error("corrected data changed without strobe");
endmodule : argl_checker

bind argl_top argl_checker chk (.core_clk(core_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .res_valid(res_valid),
   .conversion_result(conversion_result), .res_is_temp(res_is_temp),
   .corr_valid(corr_valid), .corr_data(corr_data));

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the gain and limit stage
// Assumes: APB master tasks, non-temp results bypass the gain
// Notes:   Gain cases and flag cases are table rows
`timescale 1ns/1ns
module testbench;
   typedef struct {
      logic [14:0] gain;
      logic [15:0] raw;
      logic        temp;
      logic [15:0] exp;
   } argl_row_t;
   typedef struct {
      logic [15:0] raw;
      logic [15:0] addr;
      logic [2:0]  msk;
      logic        hit;
   } argl_flag_t;

   logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic        res_valid, res_is_temp, corr_valid, irq, e;
   logic [15:0] paddr, conversion_result, corr_data;
   logic [31:0] pwdata, prdata, d;
   int          num_errors, n_compared;
   localparam logic [15:0] BA = argl_pkg::OFS_BANK_A;
   localparam logic [15:0] BB = argl_pkg::OFS_BANK_B;
   localparam logic [15:0] LV = argl_pkg::OFS_LIVE;

   // Gain cases: code, raw, temp channel, corrected result
   argl_row_t rows[7] = '{'{15'h4000, 16'h1234, 1'b1, 16'h1234},
      '{15'h2000, 16'h1234, 1'b1, 16'h091a},
      '{15'h7fff, 16'h1000, 1'b1, 16'h1fff},
      '{15'h7fff, 16'hc000, 1'b1, 16'hffff},
      '{15'h0001, 16'hffff, 1'b1, 16'h0003},
      '{15'h0000, 16'h1234, 1'b1, 16'h0000},
      '{15'h0000, 16'h1234, 1'b0, 16'h1234}};
   // Flag cases: low 0x100+0x10, high 0x200-0x20, step 0x10 from row 8
   argl_flag_t flags[11] = '{'{16'h00ff, BA, 3'h1, 1'b1},
      '{16'h0110, BA, 3'h1, 1'b1}, '{16'h0111, BB, 3'h4, 1'b0},
      '{16'h0105, BA, 3'h1, 1'b0}, '{16'h0201, BB, 3'h2, 1'b1},
      '{16'h01e0, LV, 3'h2, 1'b1}, '{16'h01df, LV, 3'h2, 1'b0},
      '{16'h01f0, BB, 3'h2, 1'b0}, '{16'h0200, BB, 3'h4, 1'b0},
      '{16'h0211, BB, 3'h4, 1'b1}, '{16'h01f0, BB, 3'h4, 1'b1}};

   argl_top dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .res_valid(res_valid), .conversion_result(conversion_result),
      .res_is_temp(res_is_temp), .corr_valid(corr_valid),
      .corr_data(corr_data), .irq(irq));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task wrap_up;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // One APB transfer; request held until pready seen at an edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         num_errors++;
         wrap_up();
      end else begin
         d = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task wr(input logic [15:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask : wr

   task rd_chk(input string name, input logic [15:0] a,
               input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, d, exp);
   endtask : rd_chk

   // One result pulse, then time for data, flags and irq to land
   task send(input logic [15:0] raw, input logic temp);
      @(posedge core_clk);
      res_valid <= 1'b1;
      conversion_result <= raw;
      res_is_temp <= temp;
      @(posedge core_clk);
      res_valid <= 1'b0;
      conversion_result <= ~raw;
      res_is_temp <= ~temp;
      repeat (4) @(posedge core_clk);
   endtask : send

   // Hang guard well above the run length of the test
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end

   initial begin
      {reset_n, psel, penable, pwrite, res_valid, res_is_temp} = 6'h0;
      {paddr, conversion_result, pwdata} = 64'h0;
      num_errors = 0;
      n_compared = 0;
      repeat (3) @(posedge core_clk);
      check("outs_rst", {pready, pslverr, corr_valid, irq, corr_data}, 32'h0);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_chk("limit_rst", 16'h20a8 + 16'(4 * i), 32'h0);
      end
      rd_chk("gain_rst", argl_pkg::OFS_TEMP_GAIN, 32'h4000);
      wr(argl_pkg::OFS_LOW_THR, 32'hffffffff);
      rd_chk("limit_upper", argl_pkg::OFS_LOW_THR, 32'h0000ffff);
      apb(1'b0, 16'h2000, 32'h0);
      check("unmapped_err", {31'h0, e}, 32'h1);
      check("unmapped_data", d, 32'h0);
      // Gain table with checks still off
      foreach (rows[i]) begin
         wr(argl_pkg::OFS_TEMP_GAIN, {17'h0, rows[i].gain});
         rd_chk("gain_rd", argl_pkg::OFS_TEMP_GAIN,
                {17'h0, rows[i].gain});
         send(rows[i].raw, rows[i].temp);
         check("corr_data", {16'h0, corr_data},
               {16'h0, rows[i].exp});
      end
      // Low to bank a, high and step routed to bank b; irq on bank a low
      wr(argl_pkg::OFS_STEP_LIM, 32'hffff);
      wr(argl_pkg::OFS_LOW_THR, 32'h100);
      wr(argl_pkg::OFS_LOW_REL, 32'h10);
      wr(argl_pkg::OFS_HIGH_THR, 32'h200);
      wr(argl_pkg::OFS_HIGH_REL, 32'h20);
      wr(argl_pkg::OFS_IRQ_MASK, 32'h01);
      wr(argl_pkg::OFS_CHECK_CTL, 32'h67);
      foreach (flags[i]) begin
         if (i == 8) wr(argl_pkg::OFS_STEP_LIM, 32'h10);
         send(flags[i].raw, 1'b0);
         apb(1'b0, flags[i].addr, 32'h0);
         check("flag_bit", d & {29'h0, flags[i].msk},
               {29'h0, flags[i].msk & {3{flags[i].hit}}}
               );
         if (flags[i].addr == BA) begin
            check("irq_set", {31'h0, irq}, {31'h0, flags[i].hit});
         end
         wr(BA, 32'h7);
         wr(BB, 32'h7);
         repeat (2) @(posedge core_clk);
         check("irq_clr", {31'h0, irq}, 32'h0);
      end
      // Unmask bank b step only; a large step must raise irq
      wr(argl_pkg::OFS_IRQ_MASK, 32'h20);
      send(16'h0100, 1'b0);
      check("irq_step", {31'h0, irq}, 32'h1);
      wr(BB, 32'h4);
      repeat (2) @(posedge core_clk);
      check("irq_w1c", {31'h0, irq}, 32'h0);
      // All flags to bank a; low and step trip together
      wr(argl_pkg::OFS_CHECK_CTL, 32'h7);
      send(16'h0050, 1'b0);
      rd_chk("route_a", BA, 32'h5);
      rd_chk("live", LV, 32'h5);
      // Second reset in mid-run restores defaults
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      check("outs_rst2", {pready, pslverr, corr_valid, irq, corr_data}, 32'h0);
      reset_n <= 1'b1;
      rd_chk("gain_rst2", argl_pkg::OFS_TEMP_GAIN, 32'h4000);
      rd_chk("bank_rst2", BA, 32'h0);
      rd_chk("step_rst2", argl_pkg::OFS_STEP_LIM, 32'h0);
      wrap_up();
   end
endmodule : testbench
